// ---- common/rsc_pkg.sv ----
package rsc_pkg;

	// Datapath and configuration store
	localparam int DW      = 8;
	localparam int CFG_W   = 16;
	localparam int CFG_D   = 8;
	localparam int CFG_AW  = 3;
	localparam int DP_IN   = 6;
	localparam int DP_OUT  = 6;
	localparam int N_COND  = 8;
	localparam int COND_SW = 3;

	// Routing matrix
	localparam int RT_W    = 32;
	localparam int RT_IW   = 5;
	localparam int RT_DP   = 0;
	localparam int RT_CTL  = 6;
	localparam int RT_PIN  = 14;
	localparam int RT_EXT  = 22;
	localparam int RT_DIV  = 30;
	localparam int RT_ONE  = 31;

	// Subblocks, requests, port
	localparam int N_SUB    = 4;
	localparam int SUB_PTA0 = 0;
	localparam int SUB_PTA1 = 1;
	localparam int SUB_DP   = 2;
	localparam int SUB_SC   = 3;
	localparam int N_REQ    = 8;
	localparam int PORT_W   = 8;
	localparam int N_OE     = 4;
	localparam int CTL_W    = 8;
	localparam int STS_W    = 8;
	localparam int DIV_DEF  = 25;

	// Datapath input positions
	localparam int DI_ADDR = 0;
	localparam int DI_SIN  = 3;
	localparam int DI_CIN  = 4;
	localparam int DI_BANK = 5;

	// Configuration word fields
	localparam int CF_OP   = 0;
	localparam int CF_SH   = 3;
	localparam int CF_CSRC = 5;
	localparam int CF_SSRC = 6;
	localparam int CF_AWR  = 7;
	localparam int CF_BSRC = 8;
	localparam int CF_CWR  = 9;

	// Condition indices
	localparam int C_EQ   = 0;
	localparam int C_LT   = 1;
	localparam int C_ZERO = 2;
	localparam int C_ONES = 3;
	localparam int C_CO   = 4;
	localparam int C_SO   = 5;
	localparam int C_CREG = 6;
	localparam int C_SREG = 7;

	// Reset values
	localparam logic [CTL_W-1:0]  CTL_RST = 8'h00;
	localparam logic [PORT_W-1:0] OEN_RST = 8'hFF;

	typedef enum logic [2:0] {
		OP_INC  = 3'h0,
		OP_DEC  = 3'h1,
		OP_ADD  = 3'h2,
		OP_SUB  = 3'h3,
		OP_AND  = 3'h4,
		OP_OR   = 3'h5,
		OP_XOR  = 3'h6,
		OP_PASS = 3'h7
	} rsc_op_t;

	typedef enum logic [1:0] {
		SH_NONE  = 2'h0,
		SH_LEFT  = 2'h1,
		SH_RIGHT = 2'h2,
		SH_SWAP  = 2'h3
	} rsc_sh_t;

	typedef enum logic [1:0] {
		CK_ALWAYS = 2'h0,
		CK_DIV    = 2'h1,
		CK_OFF    = 2'h2
	} rsc_cks_t;

	typedef enum logic [1:0] {
		OE_ALL    = 2'h0,
		OE_HALF   = 2'h1,
		OE_PAIR   = 2'h2,
		OE_SINGLE = 2'h3
	} rsc_oe_t;

endpackage

// ---- rtl/rsc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_sync
	import rsc_pkg::*;
#(
	parameter int W = PORT_W
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_r;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			q    <= '0;
		end else begin
			s1_r <= d;
			q    <= s1_r;
		end
	end

	AST_SYNC_TWO: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn, 2) |-> q == $past(d, 2))
		else $error("synchronizer latency is not two cycles");

endmodule
`default_nettype wire

// ---- rtl/rsc_cfg_ram.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_cfg_ram
	import rsc_pkg::*;
#(
	parameter int W  = CFG_W,
	parameter int D  = CFG_D,
	parameter int AW = CFG_AW
) (
	// Clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read port
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem [D];

	// Small store, so a reset clear is cheap and keeps reads defined
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < D; i++) begin
				mem[i] <= '0;
			end
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end

	AST_CFG_READ: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		re |=> rdata == $past(mem[raddr]))
		else $error("configuration read returned wrong word");

endmodule
`default_nettype wire

// ---- rtl/rsc_cell.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Carry and shift-out registered for chaining
// - Six routed datapath inputs, six outputs
// - Routed inputs pick config and serial data
// - Each output selects a condition or serial
// - Bus writes control bits driving routing
// - Status read returns live routing values, latched ones for sticky bits
// - Each status bit picks its routing signal
// - Sticky status bits cleared by read
// - Routed control bit gates subblock clocks
// - Per-subblock clock select and enable
// - Any routed signal becomes a request
// - Port: eight in, eight out, four enables
// - Optional output stage, input synchronizer
// - Enable grouping from one to eight pins
module rsc_cell
	import rsc_pkg::*;
#(
	parameter int DIV = DIV_DEF
) (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rstn,
	// System side
	input  wire logic                         sys_ctl_we,
	input  wire logic [CTL_W-1:0]             sys_ctl_wdata,
	input  wire logic                         sys_sts_re,
	output logic      [STS_W-1:0]             sys_sts_rdata,
	input  wire logic                         sys_d_we,
	input  wire logic                         sys_d_bank,
	input  wire logic [DW-1:0]                sys_d_wdata,
	input  wire logic                         sys_cfg_we,
	input  wire logic [CFG_AW-1:0]            sys_cfg_waddr,
	input  wire logic [CFG_W-1:0]             sys_cfg_wdata,
	// Static routing configuration
	input  wire logic [DP_IN-1:0][RT_IW-1:0]  dp_in_sel,
	input  wire logic [DP_OUT-1:0][COND_SW-1:0] out_sel,
	input  wire logic [STS_W-1:0][RT_IW-1:0]  sts_sel,
	input  wire logic [STS_W-1:0]             sts_sticky,
	input  wire logic [N_SUB-1:0][1:0]        cks_sel,
	input  wire logic [N_SUB-1:0]             gate_en,
	input  wire logic [N_SUB-1:0][RT_IW-1:0]  gate_idx,
	input  wire logic [N_REQ-1:0][RT_IW-1:0]  req_sel,
	input  wire logic [N_REQ-1:0]             req_edge,
	input  wire logic [PORT_W-1:0]            pin_sync_en,
	input  wire logic [PORT_W-1:0][RT_IW-1:0] pin_out_sel,
	input  wire logic [PORT_W-1:0]            pin_pipe_en,
	input  wire logic [N_OE-1:0][RT_IW-1:0]   oe_sel,
	input  wire logic [1:0]                   oe_mode,
	// Routed fabric
	input  wire logic [PORT_W-1:0]            ext_rt,
	output logic      [CTL_W-1:0]             ctl_out,
	output logic      [DP_OUT-1:0]            dp_out,
	output logic      [N_REQ-1:0]             req_out,
	output logic      [1:0]                   pta_cke,
	// Pins
	input  wire logic [PORT_W-1:0]            pin_in,
	output logic      [PORT_W-1:0]            pin_out,
	output logic      [PORT_W-1:0]            pin_oe_n
);

	localparam int DVW = $clog2(DIV + 1);

	logic [RT_W-1:0]   rt_bus;
	logic [DP_IN-1:0]  dp_in;
	logic [CFG_W-1:0]  cfg_q;
	logic              bank_r;
	logic [DW-1:0]     a_r [2];
	logic [DW-1:0]     d_r [2];
	logic              c_r;
	logic              sr_r;
	logic [DW-1:0]     a_cur;
	logic [DW-1:0]     b_cur;
	logic [DW-1:0]     sh_res;
	logic [DW:0]       alu9;
	logic              cin;
	logic              sin;
	logic              so;
	logic [N_COND-1:0] cond;
	logic [STS_W-1:0]  sts_r;
	logic [STS_W-1:0]  sts_src;
	logic [STS_W-1:0]  sts_set;
	logic [N_SUB-1:0]  cke;
	logic [DVW-1:0]    div_cnt_r;
	logic              div_pulse_r;
	logic [N_REQ-1:0]  req_src;
	logic [N_REQ-1:0]  req_prev_r;
	logic [PORT_W-1:0] pin_sync;
	logic [PORT_W-1:0] pin_rt;
	logic [PORT_W-1:0] pin_src;
	logic [PORT_W-1:0] pin_pipe_r;
	logic [PORT_W-1:0] drv;
	logic [N_OE-1:0]   oe_src;

	assign rt_bus = {1'b1, div_pulse_r, ext_rt, pin_rt, ctl_out, dp_out};

	always_comb begin
		for (int i = 0; i < DP_IN; i++) begin
			dp_in[i] = rt_bus[dp_in_sel[i]];
		end
	end

	// Enable pulse for the slow clock option
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_r   <= '0;
			div_pulse_r <= 1'b0;
		end else if (div_cnt_r == DVW'(DIV - 1)) begin
			div_cnt_r   <= '0;
			div_pulse_r <= 1'b1;
		end else begin
			div_cnt_r   <= div_cnt_r + 1'b1;
			div_pulse_r <= 1'b0;
		end
	end

	always_comb begin
		for (int k = 0; k < N_SUB; k++) begin
			case (cks_sel[k])
				CK_ALWAYS: cke[k] = 1'b1;
				CK_DIV:    cke[k] = div_pulse_r;
				default:   cke[k] = 1'b0;
			endcase
			if (gate_en[k] && !rt_bus[gate_idx[k]]) begin
				cke[k] = 1'b0;
			end
		end
	end

	// Arrays sit outside; their enable arrives one cycle late
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pta_cke <= '0;
		end else begin
			pta_cke <= {cke[SUB_PTA1], cke[SUB_PTA0]};
		end
	end

	rsc_cfg_ram #(
		.W  (CFG_W),
		.D  (CFG_D),
		.AW (CFG_AW)
	) u_cfg_ram (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.we      (sys_cfg_we),
		.waddr   (sys_cfg_waddr),
		.wdata   (sys_cfg_wdata),
		.re      (cke[SUB_DP]),
		.raddr   (dp_in[DI_ADDR +: CFG_AW]),
		.rdata   (cfg_q)
	);

	always_comb begin
		a_cur = a_r[bank_r];
		b_cur = cfg_q[CF_BSRC] ? a_r[~bank_r] : d_r[bank_r];
		cin   = cfg_q[CF_CSRC] ? c_r : dp_in[DI_CIN];
		sin   = cfg_q[CF_SSRC] ? sr_r : dp_in[DI_SIN];
		case (cfg_q[CF_OP +: 3])
			OP_INC:  alu9 = {1'b0, a_cur} + 9'h001;
			OP_DEC:  alu9 = {1'b0, a_cur} - 9'h001;
			OP_ADD:  alu9 = {1'b0, a_cur} + {1'b0, b_cur} + {8'h00, cin};
			OP_SUB:  alu9 = {1'b0, a_cur} + {1'b0, ~b_cur} + {8'h00, cin};
			OP_AND:  alu9 = {1'b0, a_cur & b_cur};
			OP_OR:   alu9 = {1'b0, a_cur | b_cur};
			OP_XOR:  alu9 = {1'b0, a_cur ^ b_cur};
			default: alu9 = {1'b0, a_cur};
		endcase
		so     = 1'b0;
		sh_res = alu9[DW-1:0];
		case (cfg_q[CF_SH +: 2])
			SH_LEFT: begin
				sh_res = {alu9[DW-2:0], sin};
				so     = alu9[DW-1];
			end
			SH_RIGHT: begin
				sh_res = {sin, alu9[DW-1:1]};
				so     = alu9[0];
			end
			SH_SWAP: begin
				sh_res = {alu9[3:0], alu9[7:4]};
			end
			default: begin
				sh_res = alu9[DW-1:0];
			end
		endcase
	end

	// Bank bit follows the config word so both apply together
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			a_r[0] <= '0;
			a_r[1] <= '0;
			bank_r <= 1'b0;
			c_r    <= 1'b0;
			sr_r   <= 1'b0;
		end else if (cke[SUB_DP]) begin
			bank_r <= dp_in[DI_BANK];
			if (cfg_q[CF_AWR]) begin
				a_r[bank_r] <= sh_res;
			end
			if (cfg_q[CF_CWR]) begin
				c_r  <= alu9[DW];
				sr_r <= so;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			d_r[0] <= '0;
			d_r[1] <= '0;
		end else if (sys_d_we) begin
			d_r[sys_d_bank] <= sys_d_wdata;
		end
	end

	always_comb begin
		cond         = '0;
		cond[C_EQ]   = a_cur == b_cur;
		cond[C_LT]   = a_cur < b_cur;
		cond[C_ZERO] = a_cur == 8'h00;
		cond[C_ONES] = a_cur == 8'hFF;
		cond[C_CO]   = alu9[DW];
		cond[C_SO]   = so;
		cond[C_CREG] = c_r;
		cond[C_SREG] = sr_r;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dp_out <= '0;
		end else begin
			for (int i = 0; i < DP_OUT; i++) begin
				dp_out[i] <= cond[out_sel[i]];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctl_out <= CTL_RST;
		end else if (sys_ctl_we) begin
			ctl_out <= sys_ctl_wdata;
		end
	end

	always_comb begin
		for (int i = 0; i < STS_W; i++) begin
			sts_src[i] = rt_bus[sts_sel[i]];
		end
		sts_set = sts_src & sts_sticky & {STS_W{cke[SUB_SC]}};
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sts_r <= '0;
		end else begin
			sts_r <= ((sts_r & ~{STS_W{sys_sts_re}}) | sts_set) & sts_sticky;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sys_sts_rdata <= '0;
		end else if (sys_sts_re) begin
			sys_sts_rdata <= (sts_r & sts_sticky) | (sts_src & ~sts_sticky);
		end
	end

	always_comb begin
		for (int j = 0; j < N_REQ; j++) begin
			req_src[j] = rt_bus[req_sel[j]];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req_prev_r <= '0;
			req_out    <= '0;
		end else begin
			req_prev_r <= req_src;
			req_out    <= req_src & ~(req_prev_r & req_edge);
		end
	end

	rsc_sync #(
		.W (PORT_W)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.d       (pin_in),
		.q       (pin_sync)
	);

	assign pin_rt = (pin_sync & pin_sync_en) | (pin_in & ~pin_sync_en);

	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			pin_src[i] = rt_bus[pin_out_sel[i]];
		end
		for (int g = 0; g < N_OE; g++) begin
			oe_src[g] = rt_bus[oe_sel[g]];
		end
		case (oe_mode)
			OE_ALL:  drv = {PORT_W{oe_src[0]}};
			OE_HALF: drv = {{4{oe_src[1]}}, {4{oe_src[0]}}};
			OE_PAIR: drv = {{2{oe_src[3]}}, {2{oe_src[2]}}, {2{oe_src[1]}}, {2{oe_src[0]}}};
			default: drv = {4'h0, oe_src};
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_pipe_r <= '0;
			pin_out    <= '0;
			pin_oe_n   <= OEN_RST;
		end else begin
			pin_pipe_r <= pin_src;
			pin_out    <= (pin_pipe_r & pin_pipe_en) | (pin_src & ~pin_pipe_en);
			pin_oe_n   <= ~drv;
		end
	end

	AST_CARRY_REG: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		cke[SUB_DP] && cfg_q[CF_CWR] |=> c_r == $past(alu9[DW]))
		else $error("registered carry does not match ALU carry");

	AST_DP_OUT_SEL: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) |-> dp_out[0] == $past(cond[out_sel[0]]))
		else $error("datapath output does not follow its condition");

	AST_CTL_WRITE: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sys_ctl_we ##1 !sys_ctl_we |=> ctl_out == $past(sys_ctl_wdata, 2) && $stable(ctl_out))
		else $error("control write not held on routing");

	AST_STS_READ: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sys_sts_re |=> sys_sts_rdata ==
			$past((sts_r & sts_sticky) | (sts_src & ~sts_sticky)))
		else $error("status read returned wrong value");

	AST_STS_SET_WINS: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sts_set[STS_W-1] |=> sts_r[STS_W-1])
		else $error("sticky status event lost");

	AST_STS_CLEAR: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sys_sts_re && !sts_set[STS_W-1] |=> !sts_r[STS_W-1])
		else $error("sticky status not cleared by read");

	AST_DP_CKE_OFF: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		cks_sel[SUB_DP] == CK_OFF |=> $stable(a_r[0]) && $stable(c_r) && $stable(bank_r))
		else $error("datapath advanced while its clock was off");

	AST_REQ_PULSE: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		req_edge[N_REQ-1] && $stable(req_edge[N_REQ-1]) && req_out[N_REQ-1]
			|=> !req_out[N_REQ-1])
		else $error("edge request longer than one cycle");

	AST_OE_GANGED: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		oe_mode == OE_ALL |=> pin_oe_n == {PORT_W{~$past(oe_src[0])}})
		else $error("ganged output enable not applied to all pins");

	AST_PIN_PIPE: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn, 2) && pin_pipe_en[0] && $past(pin_pipe_en[0])
			|=> pin_out[0] == $past(pin_src[0], 2))
		else $error("pipelined pin output has wrong latency");

endmodule
`default_nettype wire

// ---- dv/rsc_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_far_model
	import rsc_pkg::*;
(
	// Clock
	input  wire logic              ref_clk,
	// Levels asked for by the bench
	input  wire logic [PORT_W-1:0] ext_nxt,
	input  wire logic [PORT_W-1:0] pin_nxt,
	// Toward the cell
	output logic      [PORT_W-1:0] ext_rt,
	output logic      [PORT_W-1:0] pin_in
);
	initial begin
		ext_rt = '0;
		pin_in = '0;
	end
	// Neighbour logic shares the cell clock
	always @(posedge ref_clk) begin
		ext_rt <= ext_nxt;
	end
	// Pins move between edges, as an unclocked source would
	always @(negedge ref_clk) begin
		pin_in <= pin_nxt;
	end
endmodule
`default_nettype wire

// ---- dv/test_routing_status_control_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_routing_status_control_sync;
	import rsc_pkg::*;
	localparam int DV = 3;
	logic                           ref_clk, rstn, sys_ctl_we, sys_sts_re, sys_d_we, sys_d_bank;
	logic                           sys_cfg_we;
	logic [PORT_W-1:0]              sys_ctl_wdata, sys_sts_rdata, sys_d_wdata, sts_sticky;
	logic [PORT_W-1:0]              req_edge, pin_sync_en, pin_pipe_en, ext_rt, ctl_out, req_out;
	logic [PORT_W-1:0]              pin_in, pin_out, pin_oe_n, ext_nxt, pin_nxt, d, v, old;
	logic [PORT_W-1:0]              ctl_m, ext_m;
	logic [CFG_AW-1:0]              sys_cfg_waddr;
	logic [CFG_W-1:0]               sys_cfg_wdata;
	logic [DP_IN-1:0][RT_IW-1:0]    dp_in_sel;
	logic [DP_OUT-1:0][COND_SW-1:0] out_sel;
	logic [DP_OUT-1:0]              dp_out;
	logic [PORT_W-1:0][RT_IW-1:0]   sts_sel, req_sel, pin_out_sel;
	logic [N_SUB-1:0][RT_IW-1:0]    gate_idx;
	logic [N_OE-1:0][RT_IW-1:0]     oe_sel;
	logic [N_SUB-1:0][1:0]          cks_sel;
	logic [N_SUB-1:0]               gate_en;
	logic [1:0]                     oe_mode, pta_cke;
	logic [31:0]                    seed, c0, c1;
	int                             n_mismatch, n_tests;

	rsc_cell #(.DIV(DV)) uut (
		.ref_clk(ref_clk), .rstn(rstn), .sys_ctl_we(sys_ctl_we), .sys_ctl_wdata(sys_ctl_wdata),
		.sys_sts_re(sys_sts_re), .sys_sts_rdata(sys_sts_rdata), .sys_d_we(sys_d_we),
		.sys_d_bank(sys_d_bank), .sys_d_wdata(sys_d_wdata), .sys_cfg_we(sys_cfg_we),
		.sys_cfg_waddr(sys_cfg_waddr), .sys_cfg_wdata(sys_cfg_wdata), .dp_in_sel(dp_in_sel),
		.out_sel(out_sel), .sts_sel(sts_sel), .sts_sticky(sts_sticky), .cks_sel(cks_sel),
		.gate_en(gate_en), .gate_idx(gate_idx), .req_sel(req_sel), .req_edge(req_edge),
		.pin_sync_en(pin_sync_en), .pin_out_sel(pin_out_sel), .pin_pipe_en(pin_pipe_en),
		.oe_sel(oe_sel), .oe_mode(oe_mode), .ext_rt(ext_rt), .ctl_out(ctl_out), .dp_out(dp_out),
		.req_out(req_out), .pta_cke(pta_cke), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n)
	);
	rsc_far_model far (.ref_clk(ref_clk), .ext_nxt(ext_nxt), .pin_nxt(pin_nxt),
		.ext_rt(ext_rt), .pin_in(pin_in));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0] ^ seed[23:16];
	endfunction
	function automatic logic [7:0] rev(input logic [7:0] x);
		for (int i = 0; i < 8; i++) begin
			rev[i] = x[7 - i];
		end
	endfunction
	function automatic logic [7:0] oe_exp(input logic [1:0] m, input logic [3:0] r);
		logic [7:0] en;
		for (int i = 0; i < 8; i++) begin
			case (m)
				OE_ALL:  en[i] = r[0];
				OE_HALF: en[i] = r[i / 4];
				OE_PAIR: en[i] = r[i / 2];
				default: en[i] = (i < 4) ? r[i] : 1'b0;
			endcase
		end
		return ~en;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, s, seen, exp);
		end
	endtask
	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic ctl_wr(input logic [7:0] x);
		@(posedge ref_clk);
		sys_ctl_we <= 1'b1;
		sys_ctl_wdata <= x;
		@(posedge ref_clk);
		sys_ctl_we <= 1'b0;
		ctl_m = x;
	endtask
	task automatic cfg_wr(input logic [CFG_AW-1:0] a, input logic [CFG_W-1:0] w);
		@(posedge ref_clk);
		sys_cfg_we <= 1'b1;
		sys_cfg_waddr <= a;
		sys_cfg_wdata <= w;
		@(posedge ref_clk);
		sys_cfg_we <= 1'b0;
	endtask
	task automatic d_wr(input logic b, input logic [7:0] x);
		@(posedge ref_clk);
		sys_d_we <= 1'b1;
		sys_d_bank <= b;
		sys_d_wdata <= x;
		@(posedge ref_clk);
		sys_d_we <= 1'b0;
	endtask
	task automatic ext_wr(input logic [7:0] x);
		@(posedge ref_clk);
		ext_nxt <= x;
		ext_m = x;
		tick(3);
	endtask
	task automatic sts_rd(output logic [7:0] q);
		@(posedge ref_clk);
		sys_sts_re <= 1'b1;
		@(posedge ref_clk);
		sys_sts_re <= 1'b0;
		@(negedge ref_clk);
		q = sys_sts_rdata;
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Run takes under a thousand cycles
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		rstn = 1'b0;
		{sys_ctl_we, sys_sts_re, sys_d_we, sys_d_bank, sys_cfg_we} = '0;
		{sys_ctl_wdata, sys_d_wdata, sys_cfg_waddr, sys_cfg_wdata, ext_nxt, pin_nxt} = '0;
		{gate_en, gate_idx, cks_sel, oe_mode, out_sel, ctl_m, ext_m} = '0;
		{n_mismatch, n_tests} = '0;
		seed = 32'h4447;
		for (int i = 0; i < 8; i++) begin
			sts_sel[i] = RT_IW'(RT_EXT + i);
			req_sel[i] = RT_IW'(RT_EXT + i);
			pin_out_sel[i] = RT_IW'(RT_CTL + i);
			dp_in_sel[i % 6] = RT_IW'(RT_CTL + i % 6);
			oe_sel[i % 4] = RT_IW'(RT_CTL + i % 4);
		end
		dp_in_sel[DI_BANK] = RT_IW'(RT_CTL);
		out_sel[0] = COND_SW'(C_ONES);
		out_sel[1] = COND_SW'(C_ZERO);
		out_sel[2] = COND_SW'(C_CREG);
		out_sel[3] = COND_SW'(C_LT);
		{sts_sticky, req_edge, pin_pipe_en} = {8'hF0, 8'hF0, 8'h0F};
		pin_sync_en = 8'hF0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check({ctl_out, req_out, pin_out, pin_oe_n}, 32'h000000FF, "reset");
		check({dp_out, pta_cke, sys_sts_rdata}, 32'h0, "reset");
		@(posedge ref_clk);
		rstn <= 1'b1;
		done("reset");
		// Idle words at 2 and 3 keep the accumulators still between passes
		ctl_wr(8'h02);
		d_wr(1'b0, 8'h80);
		d_wr(1'b1, 8'h7F);
		cfg_wr(3'h0, 16'h0282);
		cfg_wr(3'h1, 16'h00A2);
		cfg_wr(3'h2, 16'h0007);
		cfg_wr(3'h3, 16'h0007);
		repeat (2) begin
			@(posedge ref_clk);
			sys_ctl_we <= 1'b1;
			sys_ctl_wdata <= 8'h00;
			@(posedge ref_clk);
			sys_ctl_wdata <= 8'h01;
			@(posedge ref_clk);
			sys_ctl_wdata <= 8'h02;
			@(posedge ref_clk);
			sys_ctl_we <= 1'b0;
			tick(3);
		end
		ctl_wr(8'h03);
		tick(3);
		@(negedge ref_clk);
		check(dp_out, 6'h05, "high byte");
		ctl_wr(8'h02);
		tick(3);
		@(negedge ref_clk);
		check(dp_out, 6'h0E, "low byte");
		done("datapath");
		for (int k = 0; k < 4; k++) begin
			old = ctl_m;
			v = rnd();
			ctl_wr(v);
			@(negedge ref_clk);
			check(ctl_out, v, "ctl");
			check(pin_out, old, "pin hold");
			@(negedge ref_clk);
			check(pin_out, {v[7:4], old[3:0]}, "pin direct");
			@(negedge ref_clk);
			check(pin_out, v, "pin piped");
		end
		done("control");
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			pin_out_sel[i] <= RT_IW'(RT_PIN + i);
		end
		pin_pipe_en <= '0;
		tick(3);
		old = '0;
		for (int k = 0; k < 4; k++) begin
			v = rnd();
			@(posedge ref_clk);
			pin_nxt <= v;
			repeat (2) @(negedge ref_clk);
			check(pin_out, {old[7:4], v[3:0]}, "raw pin");
			@(negedge ref_clk);
			check(pin_out, {old[7:4], v[3:0]}, "sync pin");
			@(negedge ref_clk);
			check(pin_out, v, "sync pin");
			old = v;
		end
		done("pins");
		for (int m = 0; m < 4; m++) begin
			for (int j = 0; j < 2; j++) begin
				v = j ? ~v : rnd();
				@(posedge ref_clk);
				oe_mode <= m[1:0];
				ctl_wr(v);
				tick(2);
				@(negedge ref_clk);
				check(pin_oe_n, oe_exp(m[1:0], v[3:0]), "oe");
			end
		end
		done("enables");
		ext_wr(8'h00);
		sts_rd(d);
		v = rnd();
		ext_wr(v);
		ext_wr(8'h00);
		sts_rd(d);
		check(d, v & 8'hF0, "held");
		sts_rd(d);
		check(d, 8'h00, "cleared");
		ext_wr(v);
		sts_rd(d);
		check(d, v, "live");
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			sts_sel[i] <= RT_IW'(RT_EXT + 7 - i);
		end
		sts_sticky <= '0;
		sts_rd(d);
		check(d, rev(v), "per bit");
		done("status");
		for (int k = 0; k < 6; k++) begin
			old = ext_m;
			v = (k == 0) ? 8'hFF : rnd();
			@(posedge ref_clk);
			ext_nxt <= v;
			ext_m = v;
			repeat (2) @(negedge ref_clk);
			check(req_out, old & 8'h0F, "req early");
			@(negedge ref_clk);
			check(req_out, (v & 8'h0F) | (v & ~old & 8'hF0), "req");
			@(negedge ref_clk);
			check(req_out, v & 8'h0F, "req pulse end");
		end
		done("requests");
		@(posedge ref_clk);
		gate_en <= 4'h1;
		gate_idx[0] <= RT_IW'(RT_CTL + 4);
		for (int j = 0; j < 3; j++) begin
			@(posedge ref_clk);
			cks_sel[1] <= (j == 2) ? CK_OFF : CK_DIV;
			cks_sel[SUB_DP] <= (j == 2) ? CK_OFF : CK_ALWAYS;
			ctl_wr(j[0] ? 8'h10 : 8'h00);
			tick(3);
			{c0, c1} = '0;
			repeat (12) begin
				@(negedge ref_clk);
				c0 = c0 + pta_cke[0];
				c1 = c1 + pta_cke[1];
			end
			check(c0, j[0] ? 12 : 0, "gated");
			check(c1, (j == 2) ? 0 : 12 / DV, "divided");
		end
		done("clocks");
		for (int k = 0; k < 16; k++) begin
			v = rnd();
			ctl_wr(v);
			@(negedge ref_clk);
			check(ctl_out, v, "random ctl");
			ext_wr(~v);
			sts_rd(d);
			check(d, rev(~v), "random status");
		end
		done("random");
		close_out();
	end
endmodule
`default_nettype wire
